// ---- src/isd_pkg.sv ----
`default_nettype none
package isd_pkg;
  // ==========================================================
  // sizes
  localparam int CHANNELS   = 4;
  localparam int CNT_W      = 24;
  localparam int CLK_MHZ    = 125;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] SPARK_CMD_OFS = 8'h00;
  localparam logic [7:0] DAC_CMD_OFS   = 8'h04;
  localparam logic [7:0] MODE_CMD_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0C;
  // ==========================================================
  // spark command fields
  localparam int SP_END_LSB   = 0;
  localparam int SP_OS_LSB    = 2;
  localparam int SP_LVC_BIT   = 4;
  localparam int SP_SOFT_BIT  = 5;
  localparam int SP_GAIN_BIT  = 6;
  localparam int SP_OVL_BIT   = 7;
  localparam int SP_DWEN_BIT  = 8;
  localparam int SP_DW_LSB    = 9;
  // dac command fields
  localparam int DAC_NOM_LSB  = 0;
  localparam int DAC_PCT_LSB  = 5;
  localparam int DAC_MAX_LSB  = 8;
  // mode command field
  localparam int MODE_GEN_LSB = 8;
  // status fields
  localparam int ST_OS_LSB    = 0;
  localparam int ST_DW_LSB    = 4;
  localparam int ST_LVC_LSB   = 8;
  localparam int ST_SPK_LSB   = 12;
  // ==========================================================
  // reset values
  localparam logic [31:0] SPARK_CMD_RST = 32'h0000_090D;
  localparam logic [31:0] DAC_CMD_RST   = 32'h0000_008A;
  localparam logic [31:0] MODE_CMD_RST  = 32'h0000_0000;
  // ==========================================================
  // open secondary intervals, microseconds
  localparam int OS_T0_US = 10;
  localparam int OS_T1_US = 20;
  localparam int OS_T2_US = 50;
  localparam int OS_T3_US = 100;
  // maximum dwell intervals, milliseconds
  localparam int DW_T0_MS = 2;
  localparam int DW_T1_MS = 4;
  localparam int DW_T2_MS = 8;
  localparam int DW_T3_MS = 16;
  localparam int DW_T4_MS = 32;
  localparam int DW_TX_MS = 64;
  localparam int US_PER_MS = 1000;
endpackage : isd_pkg
`default_nettype wire

// ---- src/isd_chan_if.sv ----
`default_nettype none
interface isd_chan_if;
  import isd_pkg::*;
  logic             gate_cmd;
  logic             spark_begin;
  logic             spark_end_above;
  logic             os_above;
  logic             gen_mode;
  logic             dwell_en;
  logic [CNT_W-1:0] os_limit;
  logic [CNT_W-1:0] dwell_limit;
  logic             os_fault;
  logic             dwell_exp;
  logic             spark_active;
  modport ctrl (output gate_cmd, spark_begin, spark_end_above, os_above, gen_mode, dwell_en,
                output os_limit, dwell_limit, input os_fault, dwell_exp, spark_active);
  modport chan (input gate_cmd, spark_begin, spark_end_above, os_above, gen_mode, dwell_en,
                input os_limit, dwell_limit, output os_fault, dwell_exp, spark_active);
endinterface : isd_chan_if
`default_nettype wire

// ---- src/isd_channel.sv ----
`default_nettype none
module isd_channel
  import isd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // channel bundle
  isd_chan_if.chan ch
);
  import isd_pkg::*;

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic             gate_q;
  logic             os_q;
  logic [CNT_W-1:0] os_cnt;
  logic [CNT_W-1:0] dw_cnt;
  logic             os_fault;
  logic             dwell_exp;
  logic             spark_active;

  wire gate_rise  = ch.gate_cmd & ~gate_q;
  wire os_rise    = ch.os_above & ~os_q;
  wire os_set     = ch.os_above & ~os_rise & (os_cnt >= ch.os_limit);
  wire dw_set     = ch.gate_cmd & ~gate_rise & ~ch.gen_mode & ch.dwell_en
                    & (dw_cnt >= ch.dwell_limit);
  wire ignition   = ~ch.gen_mode;

  assign ch.os_fault     = os_fault;
  assign ch.dwell_exp    = dwell_exp;
  assign ch.spark_active = spark_active;

  // ==========================================================
  // edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
      os_q   <= 1'b0;
    end else begin
      gate_q <= ch.gate_cmd;
      os_q   <= ch.os_above;
    end
  end

  // ==========================================================
  // spark duration: set above begin level after turn-off, drop below end level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spark_active <= 1'b0;
    end else if (ch.gate_cmd || ch.gen_mode) begin
      spark_active <= 1'b0;
    end else if (ch.spark_begin) begin
      spark_active <= 1'b1;
    end else if (!ch.spark_end_above) begin
      spark_active <= 1'b0;
    end
  end

  // ==========================================================
  // open secondary timer, runs while primary stays above the clamp level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_cnt <= '0;
    end else if (os_rise) begin
      os_cnt <= CNT_W'(1);
    end else if (ch.os_above && os_cnt != CNT_MAX) begin
      os_cnt <= os_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_fault <= 1'b0;
    end else if (os_set && ignition) begin
      os_fault <= 1'b1;
    end else if (gate_rise) begin
      os_fault <= 1'b0;
    end
  end

  // ==========================================================
  // dwell timer, starts at gate-on command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dw_cnt <= '0;
    end else if (gate_rise) begin
      dw_cnt <= CNT_W'(1);
    end else if (ch.gate_cmd && dw_cnt != CNT_MAX) begin
      dw_cnt <= dw_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell_exp <= 1'b0;
    end else if (dw_set) begin
      dwell_exp <= 1'b1;
    end else if (gate_rise || !ch.dwell_en || ch.gen_mode) begin
      dwell_exp <= 1'b0;
    end
  end
endmodule : isd_channel
`default_nettype wire

// ---- src/isd_spark_dwell_ctrl.sv ----
// Design decisions made here: the register offsets and the APB register port.
`default_nettype none
module isd_spark_dwell_ctrl
  import isd_pkg::*;
#(
  parameter int CYC_PER_US = CLK_MHZ
) (
  // apb clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // host capture clock
  input  wire logic                capture_clk,
  // pins, asynchronous
  input  wire logic [CHANNELS-1:0] gate_cmd_in,
  input  wire logic [CHANNELS-1:0] collector_feedback_begin,
  input  wire logic [CHANNELS-1:0] collector_feedback_end,
  input  wire logic [CHANNELS-1:0] collector_feedback_os,
  input  wire logic                output_disable_in,
  input  wire logic                battery_supply_overvoltage,
  // gate drive
  output logic      [CHANNELS-1:0] gate_drive_output,
  output logic      [CHANNELS-1:0] lv_clamp_out,
  // analog setup
  output logic      [1:0]          end_spark_threshold_field,
  output logic                     amp_gain_two,
  output logic      [4:0]          nominal_current_code,
  output logic      [3:0]          maximum_current_code,
  output logic      [2:0]          overlap_raise_sel,
  output logic                     overlap_raise,
  // capture side
  output logic      [CHANNELS-1:0] spark_duration_out
);
  import isd_pkg::*;

  // ==========================================================
  // registers
  logic [11:0] spark_cmd;
  logic [11:0] dac_cmd;
  logic [11:0] mode_cmd;

  wire [1:0] end_sel       = spark_cmd[SP_END_LSB +: 2];
  wire [1:0] os_sel        = spark_cmd[SP_OS_LSB +: 2];
  wire       lvc_en        = spark_cmd[SP_LVC_BIT];
  wire       soft_off_enable = spark_cmd[SP_SOFT_BIT];
  wire       gain_sel      = spark_cmd[SP_GAIN_BIT];
  wire       overlap_en    = spark_cmd[SP_OVL_BIT];
  wire       dwell_limit_enable = spark_cmd[SP_DWEN_BIT];
  wire [2:0] dwell_limit_field  = spark_cmd[SP_DW_LSB +: 3];
  wire [CHANNELS-1:0] general_gate_mode = mode_cmd[MODE_GEN_LSB +: CHANNELS];

  // ==========================================================
  // apb decode
  wire acc       = psel & penable;
  wire hit_spark = paddr == SPARK_CMD_OFS;
  wire hit_dac   = paddr == DAC_CMD_OFS;
  wire hit_mode  = paddr == MODE_CMD_OFS;
  wire hit_stat  = paddr == STATUS_OFS;
  wire mapped    = hit_spark | hit_dac | hit_mode | hit_stat;
  wire wr_spark  = acc & pwrite & hit_spark;
  wire wr_dac    = acc & pwrite & hit_dac;
  wire wr_mode   = acc & pwrite & hit_mode;

  logic [CHANNELS-1:0] os_fault;
  logic [CHANNELS-1:0] dwell_exp;
  logic [CHANNELS-1:0] spark_active;

  wire [15:0] status_word = {spark_active, lv_clamp_out, dwell_exp, os_fault};
  wire [31:0] read_word   = hit_spark ? {20'h0_0000, spark_cmd} :
                            hit_dac   ? {20'h0_0000, dac_cmd}   :
                            hit_mode  ? {20'h0_0000, mode_cmd}  :
                            hit_stat  ? {16'h0000, status_word} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spark_cmd <= SPARK_CMD_RST[11:0];
      dac_cmd   <= DAC_CMD_RST[11:0];
      mode_cmd  <= MODE_CMD_RST[11:0];
    end else begin
      if (wr_spark) spark_cmd <= pwdata[11:0];
      if (wr_dac)   dac_cmd   <= pwdata[11:0];
      if (wr_mode)  mode_cmd  <= pwdata[11:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (psel & ~penable & ~pwrite) ? read_word : 32'h0000_0000;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // ==========================================================
  // pin synchronisers
  localparam int SYN_W = 4 * CHANNELS + 2;
  logic [SYN_W-1:0] syn1;
  logic [SYN_W-1:0] syn2;
  wire  [SYN_W-1:0] pins = {battery_supply_overvoltage, output_disable_in,
                            collector_feedback_os, collector_feedback_end,
                            collector_feedback_begin, gate_cmd_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syn1 <= '0;
      syn2 <= '0;
    end else begin
      syn1 <= pins;
      syn2 <= syn1;
    end
  end

  wire [CHANNELS-1:0] s_cmd   = syn2[0 +: CHANNELS];
  wire [CHANNELS-1:0] s_begin = syn2[CHANNELS +: CHANNELS];
  wire [CHANNELS-1:0] s_end   = syn2[2*CHANNELS +: CHANNELS];
  wire [CHANNELS-1:0] s_os    = syn2[3*CHANNELS +: CHANNELS];
  wire                s_dis   = syn2[4*CHANNELS];
  wire                s_ov    = syn2[4*CHANNELS+1];

  // ==========================================================
  // interval limits in pclk cycles
  wire [31:0] os_us  = (os_sel == 2'd0) ? OS_T0_US :
                       (os_sel == 2'd1) ? OS_T1_US :
                       (os_sel == 2'd2) ? OS_T2_US : OS_T3_US;
  wire [31:0] dw_ms  = (dwell_limit_field == 3'd0) ? DW_T0_MS :
                       (dwell_limit_field == 3'd1) ? DW_T1_MS :
                       (dwell_limit_field == 3'd2) ? DW_T2_MS :
                       (dwell_limit_field == 3'd3) ? DW_T3_MS :
                       (dwell_limit_field == 3'd4) ? DW_T4_MS : DW_TX_MS;
  wire [31:0] os_cyc = os_us * CYC_PER_US;
  wire [31:0] dw_cyc = dw_ms * US_PER_MS * CYC_PER_US;
  wire [CNT_W-1:0] os_limit    = os_cyc[CNT_W-1:0];
  wire [CNT_W-1:0] dwell_limit = dw_cyc[CNT_W-1:0];

  // ==========================================================
  // channels
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      isd_chan_if bus ();
      assign bus.gate_cmd        = s_cmd[gi];
      assign bus.spark_begin     = s_begin[gi];
      assign bus.spark_end_above = s_end[gi];
      assign bus.os_above        = s_os[gi];
      assign bus.gen_mode        = general_gate_mode[gi];
      assign bus.dwell_en        = dwell_limit_enable;
      assign bus.os_limit        = os_limit;
      assign bus.dwell_limit     = dwell_limit;
      assign os_fault[gi]        = bus.os_fault;
      assign dwell_exp[gi]       = bus.dwell_exp;
      assign spark_active[gi]    = bus.spark_active;
      isd_channel u_ch (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (bus.chan)
      );
    end
  endgenerate

  // ==========================================================
  // gate control
  wire [CHANNELS-1:0] ign      = ~general_gate_mode;
  wire                soft_evt = s_dis | s_ov;
  wire [CHANNELS-1:0] soft_req = {CHANNELS{soft_off_enable}}
                                 & ({CHANNELS{soft_evt}} | dwell_exp);
  wire [CHANNELS-1:0] next_lvc = {CHANNELS{lvc_en}} & ign
                                 & (os_fault | soft_req);
  wire [CHANNELS-1:0] next_gate = s_cmd & ~{CHANNELS{soft_evt}} & ~dwell_exp;

  // overlap: two or more ignition drivers commanded on
  wire [CHANNELS-1:0] ign_on = s_cmd & ign;
  logic [2:0] on_count;
  always_comb begin
    on_count = 3'd0;
    for (int i = 0; i < CHANNELS; i++) begin
      on_count = on_count + {2'b00, ign_on[i]};
    end
  end
  wire next_overlap = overlap_en & (on_count >= 3'd2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_drive_output <= '0;
      lv_clamp_out      <= '0;
      overlap_raise     <= 1'b0;
    end else begin
      gate_drive_output <= next_gate;
      lv_clamp_out      <= next_lvc;
      overlap_raise     <= next_overlap;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_spark_threshold_field <= SPARK_CMD_RST[SP_END_LSB +: 2];
      amp_gain_two              <= SPARK_CMD_RST[SP_GAIN_BIT];
      nominal_current_code      <= DAC_CMD_RST[DAC_NOM_LSB +: 5];
      maximum_current_code      <= DAC_CMD_RST[DAC_MAX_LSB +: 4];
      overlap_raise_sel         <= DAC_CMD_RST[DAC_PCT_LSB +: 3];
    end else begin
      end_spark_threshold_field <= end_sel;
      amp_gain_two              <= gain_sel;
      nominal_current_code      <= dac_cmd[DAC_NOM_LSB +: 5];
      maximum_current_code      <= dac_cmd[DAC_MAX_LSB +: 4];
      overlap_raise_sel         <= dac_cmd[DAC_PCT_LSB +: 3];
    end
  end

  // ==========================================================
  // spark duration toward host capture clock
  logic [CHANNELS-1:0] cap1;
  always_ff @(posedge capture_clk or negedge presetn) begin
    if (!presetn) begin
      cap1               <= '0;
      spark_duration_out <= '0;
    end else begin
      cap1               <= spark_active;
      spark_duration_out <= cap1;
    end
  end
endmodule : isd_spark_dwell_ctrl
`default_nettype wire

// ---- tb/isd_sdc_asserts.sv ----
`default_nettype none
module isd_sdc_asserts
  import isd_pkg::*;
#(
  parameter int CYC_PER_US = CLK_MHZ
) (
  // apb
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // pins
  input wire logic [CHANNELS-1:0] gate_cmd_in,
  input wire logic                output_disable_in,
  input wire logic                battery_supply_overvoltage,
  input wire logic [CHANNELS-1:0] gate_drive_output,
  input wire logic [CHANNELS-1:0] lv_clamp_out,
  // analog setup
  input wire logic [1:0]          end_spark_threshold_field,
  input wire logic                amp_gain_two,
  input wire logic [4:0]          nominal_current_code,
  input wire logic [3:0]          maximum_current_code,
  input wire logic [2:0]          overlap_raise_sel,
  input wire logic                overlap_raise
);
  timeunit 1ns;
  timeprecision 100ps;
  import isd_pkg::*;
  // ==========
  // write decode and clamp enable shadow
  wire logic acc_wr = psel && penable && pready && pwrite;
  wire logic wr_sp  = acc_wr && (paddr == SPARK_CMD_OFS);
  wire logic wr_dac = acc_wr && (paddr == DAC_CMD_OFS);
  logic      lv_en;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      lv_en <= 1'b0;
    else if (wr_sp)
      lv_en <= pwdata[SP_LVC_BIT];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // properties
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_err_data;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("bad error answer");
  property p_spark_fields;
    logic [31:0] d;
    (wr_sp, d = pwdata) |-> ##2
      end_spark_threshold_field == d[1:0] && amp_gain_two == d[SP_GAIN_BIT];
  endproperty
  a_spark_fields: assert property (p_spark_fields) else $error("spark fields");
  property p_dac_fields;
    logic [31:0] d;
    (wr_dac, d = pwdata) |-> ##2 nominal_current_code == d[4:0]
      && maximum_current_code == d[11:8] && overlap_raise_sel == d[7:5];
  endproperty
  a_dac_fields: assert property (p_dac_fields) else $error("dac fields");
  property p_no_overlap;
    ($countones(gate_cmd_in) < 2)[*6] |-> !overlap_raise;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("raise without overlap");
  property p_gate_idle;
    (gate_cmd_in == '0)[*6] |-> gate_drive_output == '0;
  endproperty
  a_gate_idle: assert property (p_gate_idle) else $error("gate on without command");
  property p_disable_off;
    output_disable_in[*6] |-> gate_drive_output == '0;
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("gate on while disabled");
  property p_ovp_off;
    battery_supply_overvoltage[*6] |-> gate_drive_output == '0;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("gate on in overvoltage");
  property p_clamp_off;
    (!lv_en)[*4] |-> lv_clamp_out == '0;
  endproperty
  a_clamp_off: assert property (p_clamp_off) else $error("clamp while disabled");
endmodule : isd_sdc_asserts
`default_nettype wire

// ---- tb/isd_host_model.sv ----
`default_nettype none
module isd_host_model (
  // capture side
  input wire logic capture_clk,
  input wire logic presetn,
  input wire logic spark_in,
  // last pulse width in capture clocks
  output var int   width
);
  timeunit 1ns;
  timeprecision 100ps;
  int run;
  // input capture of the spark pulse width
  always @(posedge capture_clk or negedge presetn) begin
    if (!presetn) begin
      run = 0;
      width = 0;
    end else if (spark_in === 1'b1) begin
      run = run + 1;
    end else if (run != 0) begin
      width = run;
      run = 0;
    end
  end
endmodule : isd_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import isd_pkg::*;
  localparam int CYC_PER_US = 1;
  localparam logic [31:0] SP = 32'h0000_01B1;
  logic        pclk, presetn, psel, penable, pwrite, capture_clk, odis, ovp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, gain, ovr;
  logic [3:0]  gate, fb_b, fb_e, fb_os, gdo, lvc, spk, maxc;
  logic [1:0]  endf;
  logic [4:0]  nom;
  logic [2:0]  ovs;
  int          fails = 0, n_compared = 0, cyc = 0, width, lim;
  int          os_us[4] = '{OS_T0_US, OS_T1_US, OS_T2_US, OS_T3_US};
  int          dw_ms[5] = '{DW_T0_MS, DW_T0_MS, DW_T0_MS, DW_T1_MS, DW_T0_MS};
  logic [31:0] dw_cmd[5] = '{SP, 32'h0000_00B1, SP, 32'h0000_03B1, 32'h0000_0191};
  logic [31:0] dw_st[5] = '{32'h0000_0110, 0, 0, 32'h0000_0110, 32'h0000_0010};
  isd_spark_dwell_ctrl #(.CYC_PER_US(CYC_PER_US)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_clk(capture_clk), .gate_cmd_in(gate), .collector_feedback_begin(fb_b),
    .collector_feedback_end(fb_e), .collector_feedback_os(fb_os),
    .output_disable_in(odis), .battery_supply_overvoltage(ovp), .gate_drive_output(gdo),
    .lv_clamp_out(lvc), .end_spark_threshold_field(endf), .amp_gain_two(gain),
    .nominal_current_code(nom), .maximum_current_code(maxc), .overlap_raise_sel(ovs),
    .overlap_raise(ovr), .spark_duration_out(spk));
  isd_host_model host (.capture_clk(capture_clk), .presetn(presetn), .spark_in(spk[0]),
    .width(width));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    capture_clk = 1'b0;
    #3.3;
    forever #7.5 capture_clk = ~capture_clk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end
  // ==========
  // access tasks
  task test_done();
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
  endtask : rdchk
  // ==========
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, odis, ovp} = '0;
    {paddr, pwdata, gate, fb_b, fb_e, fb_os} = '0;
    wt(16);
    presetn <= 1'b1;
    wt(1);
    rdchk(SPARK_CMD_OFS, SPARK_CMD_RST);
    rdchk(DAC_CMD_OFS, DAC_CMD_RST);
    rdchk(MODE_CMD_OFS, MODE_CMD_RST);
    rdchk(8'h10, 32'h0000_0000);
    chk("pslverr", 1, 32'(er));
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, SPARK_CMD_OFS, 32'(i % 4) | (32'(i / 4) << SP_GAIN_BIT));
      xfer(1'b1, DAC_CMD_OFS, 32'(i) | (32'(i) << DAC_PCT_LSB) | (32'(i) << DAC_MAX_LSB));
      wt(2);
      chk("end spark", 32'(i % 4), 32'(endf));
      chk("gain", 32'(i / 4), 32'(gain));
      chk("nominal", 32'(i), 32'(nom));
      chk("maximum", 32'(i), 32'(maxc));
      chk("overlap sel", 32'(i), 32'(ovs));
    end
    xfer(1'b1, SPARK_CMD_OFS, SP);
    gate <= 4'h1;
    wt(6);
    {fb_b, fb_e} <= 8'h11;
    wt(10);
    chk("spark while on", 0, 32'(spk));
    {gate, fb_b, fb_e} <= '0;
    wt(6);
    {fb_b, fb_e} <= 8'h11;
    wt(4);
    fb_b <= 4'h0;
    rdchk(STATUS_OFS, 32'h0000_1000);
    wt(32);
    fb_e <= 4'h0;
    wt(12);
    chk("spark width", 1, 32'(width >= 19 && width <= 23));
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, SPARK_CMD_OFS, SP | (32'(s) << SP_OS_LSB));
      for (int k = 0; k < 3; k++) begin
        gate <= 4'h1;
        wt(6);
        if (k == 2) xfer(1'b1, SPARK_CMD_OFS, (SP & 32'hFFFF_FFEF) | (32'(s) << SP_OS_LSB));
        gate <= 4'h0;
        wt(6);
        fb_os <= 4'h1;
        lim = os_us[s] * CYC_PER_US;
        wt(k == 0 ? lim - 3 : lim + 3);
        fb_os <= 4'h0;
        wt(6);
        chk("clamp", 32'(k == 1), 32'(lvc[0]));
        rdchk(STATUS_OFS, k == 0 ? 0 : k == 1 ? 32'h0000_0101 : 32'h0000_0001);
      end
    end
    for (int m = 0; m < 5; m++) begin
      xfer(1'b1, SPARK_CMD_OFS, dw_cmd[m]);
      xfer(1'b1, MODE_CMD_OFS, m == 2 ? 32'h0000_0100 : 0);
      lim = dw_ms[m] * US_PER_MS * CYC_PER_US;
      gate <= 4'h1;
      wt(lim - 10);
      chk("gate before limit", 1, 32'(gdo[0]));
      wt(30);
      chk("gate after limit", 32'(dw_st[m] == 0), 32'(gdo[0]));
      chk("dwell clamp", 32'(dw_st[m][8]), 32'(lvc[0]));
      rdchk(STATUS_OFS, dw_st[m]);
      gate <= 4'h0;
      wt(6);
    end
    xfer(1'b1, MODE_CMD_OFS, 0);
    xfer(1'b1, SPARK_CMD_OFS, SP);
    for (int e = 0; e < 2; e++) begin
      gate <= 4'h1;
      wt(6);
      {ovp, odis} <= 2'(e + 1);
      wt(8);
      chk("soft off gate", 0, 32'(gdo[0]));
      chk("soft off clamp", 1, 32'(lvc[0]));
      {ovp, odis, gate} <= '0;
      wt(6);
    end
    for (int o = 0; o < 2; o++) begin
      xfer(1'b1, SPARK_CMD_OFS, o == 0 ? SP : 32'h0000_0131);
      gate <= 4'h3;
      wt(8);
      chk("overlap two on", 32'(o == 0), 32'(ovr));
      gate <= 4'h1;
      wt(8);
      chk("overlap one on", 0, 32'(ovr));
      gate <= 4'h0;
      wt(6);
    end
    test_done();
  end
endmodule : tb
bind isd_spark_dwell_ctrl isd_sdc_asserts #(.CYC_PER_US(CYC_PER_US)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gate_cmd_in(gate_cmd_in), .output_disable_in(output_disable_in),
  .battery_supply_overvoltage(battery_supply_overvoltage),
  .gate_drive_output(gate_drive_output), .lv_clamp_out(lv_clamp_out),
  .end_spark_threshold_field(end_spark_threshold_field), .amp_gain_two(amp_gain_two),
  .nominal_current_code(nominal_current_code), .maximum_current_code(maximum_current_code),
  .overlap_raise_sel(overlap_raise_sel), .overlap_raise(overlap_raise));
`default_nettype wire
